/* common/rmv_pkg.sv */
// Constants of the rms and mean-absolute-value measurement block.
// Assumes a 40 MHz system clock and 24-bit signed channel samples.
package rmv_pkg;
   // ********************************
   // Register byte offsets
   // ********************************
   localparam logic [5:0] OFF_CUR_RMS = 6'h00;   // Four words: phases A, B, C, neutral.
   localparam logic [5:0] OFF_CUR_OFFS = 6'h10;  // Four words: phases A, B, C, neutral.
   localparam logic [5:0] OFF_CUR_MAV = 6'h20;   // Three words: phases A, B, C.
   localparam logic [5:0] OFF_VOLT_RMS = 6'h2C;  // Three words: phases A, B, C.
   localparam logic [5:0] OFF_RUN = 6'h38;
   localparam logic [5:0] OFF_CONFIG = 6'h3C;
   // ********************************
   // Fields and reset values
   // ********************************
   localparam int RMS_W = 24;
   localparam int MAV_W = 20;
   localparam int DSP_W = 28;
   localparam int SQ_W = 48;
   localparam int INTEG_EN_BIT = 0;
   localparam logic [15:0] RUN_START = 16'h0001;
   localparam logic [15:0] RUN_RESET = 16'h0000;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam int OFFS_SCALE_SHIFT = 7;           // Offset is weighted by 128.
   // ********************************
   // Filters
   // ********************************
   localparam int RMS_LPF_SHIFT = 8;
   localparam int MAV_HPF_SHIFT = 10;
   localparam int MAV_LPF_SHIFT = 8;
   localparam int MAV_OUT_SHIFT = 4;
   // ********************************
   // Timing
   // ********************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int UPDATE_PERIOD_NS = 125000;      // 8 kHz result refresh.
   localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int N_CH = 7;
   localparam int N_CUR = 4;
   localparam int N_MAV = 3;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FILT = 3'b001,
      ST_ROOT = 3'b011,
      ST_STORE = 3'b010
   } rmv_state_t;
endpackage : rmv_pkg

/* rtl/rmv_measure.sv */
// Seven-channel true-rms and three-channel mean-absolute-value measurement.
// Assumes samples on the channel ports are synchronous to clk and stable
// around each 8 kHz refresh; registers are reached over Avalon-MM.
//
// Behaviour
// RQ1 - Signed 24-bit current rms for phases A, B, C and neutral, own registers.
// RQ2 - All current and voltage rms registers refresh at 8 kHz.
// RQ3 - Signed 24-bit voltage rms for phases A, B, C, separate registers.
// RQ4 - Full-scale sinusoid gives 0x3FF6A6; integrator bit 0 of configuration.
// RQ5 - Rms and mav paths each carry 2 kHz signal bandwidth.
// RQ6 - Rms results read as 32-bit words, upper eight bits zero.
// RQ7 - Add 128 times current offset to squared rms before square root.
// RQ8 - Offset reads upper four bits zero, value sign-extended to 28 bits.
// RQ9 - Mav path: high-pass, absolute value, then low-pass average.
// RQ10 - Unsigned 20-bit mav for phases A, B, C, refreshed at 8 kHz.
// RQ11 - No mav value is produced for the neutral current.
// RQ12 - Mav results read as 32-bit words, twelve top bits zero.
// RQ13 - Full-scale mav about 209,686 at 50 Hz, 210,921 at 60 Hz.
// RQ14 - Mav settles within 0.5% in 500 ms after a step.
// RQ15 - Current rms settles in 440 ms; integrator on 550/500 ms.
// RQ16 - Voltage rms settles in 440 ms at 50 and 60 Hz.
// RQ17 - Mav path runs in reduced and normal power modes alike.
// RQ18 - Host should read rms in step with voltage zero crossings.
// RQ19 - Host applies its own mav gain and offset correction.
// RQ20 - Rms path squares, low-pass filters, then takes the square root.
// RQ21 - No computation until run register holds 0x0001; clears on reset.
// RQ22 - Negative corrected square clamps to zero before the root.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module rmv_measure #(
   parameter int UPDATE_CYCLES = rmv_pkg::UPDATE_CYCLES // Clocks per refresh.
) (
   input wire logic clk,                       // 40 MHz clock.
   input wire logic reset_n,                   // Asynchronous reset, active low.
   input wire logic [5:0] avs_address,         // Byte address.
   input wire logic avs_read,                  // Read request.
   input wire logic avs_write,                 // Write request.
   input wire logic [31:0] avs_writedata,      // Write data.
   output logic [31:0] avs_readdata,           // Read data.
   output logic avs_waitrequest,               // Stall until answer.
   input wire logic signed [23:0] cur_a,       // Phase A current sample.
   input wire logic signed [23:0] cur_b,       // Phase B current sample.
   input wire logic signed [23:0] cur_c,       // Phase C current sample.
   input wire logic signed [23:0] cur_n,       // Neutral current sample.
   input wire logic signed [23:0] volt_a,      // Phase A voltage sample.
   input wire logic signed [23:0] volt_b,      // Phase B voltage sample.
   input wire logic signed [23:0] volt_c,      // Phase C voltage sample.
   output logic integrator_enable_bit,         // Integrator enable to front end.
   output logic computing                      // Computation started.
);
   // ********************************
   // Reset release
   // ********************************
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ********************************
   // Helpers
   // ********************************
   function automatic logic [27:0] sext28(input logic [23:0] v);
      sext28 = {{4{v[23]}}, v};
   endfunction : sext28

   function automatic logic [23:0] abs24(input logic signed [24:0] v);
      logic [24:0] m;
      m = v[24] ? 25'(-v) : 25'(v);
      abs24 = m[24] ? 24'hFFFFFF : m[23:0];
   endfunction : abs24

   // ********************************
   // Storage
   // ********************************
   logic [23:0] rms_reg [rmv_pkg::N_CH];
   logic [23:0] offs_reg [rmv_pkg::N_CUR];
   logic [19:0] mav_reg [rmv_pkg::N_MAV];
   logic [rmv_pkg::SQ_W-1:0] lpf_reg [rmv_pkg::N_CH];
   logic signed [31:0] dc_reg [rmv_pkg::N_MAV];
   logic [31:0] mava_reg [rmv_pkg::N_MAV];
   logic signed [23:0] snap_reg [rmv_pkg::N_CH];
   logic [15:0] run_reg;
   logic [31:0] config_reg;
   logic [12:0] tick_cnt_reg;
   logic tick_reg;
   rmv_pkg::rmv_state_t state_reg;
   logic [2:0] ch_reg;
   logic [4:0] bit_reg;
   logic [47:0] rad_reg;
   logic [23:0] root_reg;
   logic run_on;

   assign run_on = (run_reg == rmv_pkg::RUN_START);

   // ********************************
   // Refresh tick
   // ********************************
   // RQ2 8 kHz tick.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_reg <= 13'h0000;
         tick_reg <= 1'b0;
      end else if (tick_cnt_reg == 13'(UPDATE_CYCLES - 1)) begin
         tick_cnt_reg <= 13'h0000;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 13'h0001;
         tick_reg <= 1'b0;
      end
   end

   // ********************************
   // Datapath of the current channel
   // ********************************
   logic signed [23:0] smp;
   logic [47:0] sq;
   logic signed [49:0] lpf_diff;
   logic [47:0] lpf_next;
   logic signed [49:0] corr;
   logic signed [31:0] hp;
   logic signed [31:0] dc_next;
   logic [23:0] mag;
   logic signed [32:0] mav_diff;
   logic [31:0] mava_next;
   logic [31:0] mav_scaled;
   logic [23:0] trial;
   always_comb begin
      smp = snap_reg[ch_reg];
      // RQ20 square then filter.
      sq = 48'($signed(smp) * $signed(smp));
      // RQ5 RQ15 RQ16 filter bandwidth, settling.
      lpf_diff = $signed({2'b00, sq}) - $signed({2'b00, lpf_reg[ch_reg]});
      lpf_next = 48'($signed({2'b00, lpf_reg[ch_reg]}) + (lpf_diff >>> rmv_pkg::RMS_LPF_SHIFT));
      // RQ7 weighted offset added.
      corr = $signed({2'b00, lpf_next});
      if (ch_reg < 3'(rmv_pkg::N_CUR)) begin
         corr = corr + ($signed(50'($signed(sext28(offs_reg[ch_reg[1:0]]))))
                        <<< rmv_pkg::OFFS_SCALE_SHIFT);
      end
      // RQ9 high-pass, rectify, average.
      dc_next = 32'(dc_reg[ch_reg[1:0]] + ((32'(smp) - dc_reg[ch_reg[1:0]])
                                          >>> rmv_pkg::MAV_HPF_SHIFT));
      hp = 32'(smp) - dc_reg[ch_reg[1:0]];
      mag = abs24(25'(hp));
      // RQ13 RQ14 RQ17 mav averaging, runs with the rms refresh.
      mav_diff = $signed({9'h000, mag}) - $signed({1'b0, mava_reg[ch_reg[1:0]]});
      mava_next = 32'($signed({1'b0, mava_reg[ch_reg[1:0]]})
                      + (mav_diff >>> rmv_pkg::MAV_LPF_SHIFT));
      mav_scaled = mava_next >> rmv_pkg::MAV_OUT_SHIFT;
      trial = root_reg | (24'h000001 << bit_reg);
   end

   // ********************************
   // Sequencer
   // ********************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= rmv_pkg::ST_IDLE;
         ch_reg <= 3'h0;
         bit_reg <= 5'h00;
         rad_reg <= 48'h0;
         root_reg <= 24'h0;
      end else begin
         case (state_reg)
            rmv_pkg::ST_IDLE: begin
               // RQ21 idle until run.
               if (tick_reg && run_on) begin
                  ch_reg <= 3'h0;
                  state_reg <= rmv_pkg::ST_FILT;
               end
            end
            rmv_pkg::ST_FILT: begin
               // RQ22 clamp negative square.
               rad_reg <= corr[49] ? 48'h0 : corr[47:0];
               root_reg <= 24'h0;
               bit_reg <= 5'(rmv_pkg::RMS_W - 1);
               state_reg <= rmv_pkg::ST_ROOT;
            end
            rmv_pkg::ST_ROOT: begin
               // RQ20 bitwise square root.
               if (48'(trial * trial) <= rad_reg) begin
                  root_reg <= trial;
               end
               if (bit_reg == 5'h00) begin
                  state_reg <= rmv_pkg::ST_STORE;
               end else begin
                  bit_reg <= bit_reg - 5'h01;
               end
            end
            rmv_pkg::ST_STORE: begin
               if (ch_reg == 3'(rmv_pkg::N_CH - 1)) begin
                  state_reg <= rmv_pkg::ST_IDLE;
               end else begin
                  ch_reg <= ch_reg + 3'h1;
                  state_reg <= rmv_pkg::ST_FILT;
               end
            end
            default: state_reg <= rmv_pkg::ST_IDLE;
         endcase
      end
   end

   // ********************************
   // Snapshot, filters and results
   // ********************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < rmv_pkg::N_CH; i++) begin
            snap_reg[i] <= 24'h0;
            lpf_reg[i] <= 48'h0;
            rms_reg[i] <= 24'h0;
         end
         for (int i = 0; i < rmv_pkg::N_MAV; i++) begin
            dc_reg[i] <= 32'h0;
            mava_reg[i] <= 32'h0;
            mav_reg[i] <= 20'h0;
         end
      end else begin
         if (state_reg == rmv_pkg::ST_IDLE && tick_reg && run_on) begin
            snap_reg[0] <= cur_a;
            snap_reg[1] <= cur_b;
            snap_reg[2] <= cur_c;
            snap_reg[3] <= cur_n;
            snap_reg[4] <= volt_a;
            snap_reg[5] <= volt_b;
            snap_reg[6] <= volt_c;
         end
         if (state_reg == rmv_pkg::ST_FILT) begin
            lpf_reg[ch_reg] <= lpf_next;
            // RQ11 phases only.
            if (ch_reg < 3'(rmv_pkg::N_MAV)) begin
               dc_reg[ch_reg[1:0]] <= dc_next;
               mava_reg[ch_reg[1:0]] <= mava_next;
               // RQ10 saturate to 20 bits.
               mav_reg[ch_reg[1:0]] <= (mav_scaled > 32'h000F_FFFF) ? 20'hFFFFF
                                        : mav_scaled[19:0];
            end
         end
         // RQ1 RQ3 store result.
         if (state_reg == rmv_pkg::ST_STORE) begin
            rms_reg[ch_reg] <= root_reg;
         end
      end
   end

   // ********************************
   // Avalon-MM slave
   // ********************************
   logic [3:0] widx;
   logic [31:0] rd_mux;
   assign widx = avs_address[5:2];
   always_comb begin
      rd_mux = 32'h0;
      // RQ6 RQ8 RQ12 zero padding.
      if (avs_address < rmv_pkg::OFF_CUR_OFFS) begin
         rd_mux = {8'h00, rms_reg[widx[1:0]]};
      end else if (avs_address < rmv_pkg::OFF_CUR_MAV) begin
         rd_mux = {4'h0, sext28(offs_reg[widx[1:0]])};
      end else if (avs_address < rmv_pkg::OFF_VOLT_RMS) begin
         rd_mux = {12'h000, mav_reg[2'(widx - 4'h8)]};
      end else if (avs_address < rmv_pkg::OFF_RUN) begin
         rd_mux = {8'h00, rms_reg[3'(widx - 4'h7)]};
      end else if (avs_address == rmv_pkg::OFF_RUN) begin
         rd_mux = {16'h0000, run_reg};
      end else if (avs_address == rmv_pkg::OFF_CONFIG) begin
         rd_mux = config_reg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_reg <= rmv_pkg::RUN_RESET;
         config_reg <= rmv_pkg::CONFIG_RESET;
         for (int i = 0; i < rmv_pkg::N_CUR; i++) begin
            offs_reg[i] <= 24'h0;
         end
         integrator_enable_bit <= 1'b0;
         computing <= 1'b0;
      end else begin
         if (avs_write && !avs_waitrequest) begin
            if (avs_address[5:4] == rmv_pkg::OFF_CUR_OFFS[5:4]) begin
               offs_reg[widx[1:0]] <= avs_writedata[23:0];
            end else if (avs_address == rmv_pkg::OFF_RUN) begin
               run_reg <= avs_writedata[15:0];
            end else if (avs_address == rmv_pkg::OFF_CONFIG) begin
               config_reg <= {31'h0, avs_writedata[rmv_pkg::INTEG_EN_BIT]};
            end
         end
         // RQ4 integrator enable.
         integrator_enable_bit <= config_reg[rmv_pkg::INTEG_EN_BIT];
         computing <= run_on;
      end
   end

   // ********************************
   // Assertions
   // ********************************
   property p_wait_answer;
      @(posedge clk) disable iff (!rst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("no answer in one cycle");

   property p_wait_single;
      @(posedge clk) disable iff (!rst_n)
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait_single: assert property (p_wait_single) else $error("waitrequest low too long");

   property p_rms_pad;
      @(posedge clk) disable iff (!rst_n)
      avs_read && !avs_waitrequest && avs_address < rmv_pkg::OFF_CUR_OFFS
      |-> avs_readdata[31:24] == 8'h00;
   endproperty
   a_rms_pad: assert property (p_rms_pad) else $error("rms upper byte not zero"); // RQ6

   property p_offs_pad;
      @(posedge clk) disable iff (!rst_n)
      avs_read && !avs_waitrequest && avs_address[5:4] == rmv_pkg::OFF_CUR_OFFS[5:4]
      |-> avs_readdata[31:28] == 4'h0 && avs_readdata[27:24] == {4{avs_readdata[23]}};
   endproperty
   a_offs_pad: assert property (p_offs_pad) else $error("offset not sign extended"); // RQ8

   property p_mav_pad;
      @(posedge clk) disable iff (!rst_n)
      avs_read && !avs_waitrequest && avs_address >= rmv_pkg::OFF_CUR_MAV
      && avs_address < rmv_pkg::OFF_VOLT_RMS |-> avs_readdata[31:20] == 12'h000;
   endproperty
   a_mav_pad: assert property (p_mav_pad) else $error("mav top bits not zero"); // RQ12

   property p_no_run;
      @(posedge clk) disable iff (!rst_n)
      state_reg == rmv_pkg::ST_IDLE && !run_on |=> state_reg == rmv_pkg::ST_IDLE;
   endproperty
   a_no_run: assert property (p_no_run) else $error("computation without run"); // RQ21

   property p_refresh;
      @(posedge clk) disable iff (!rst_n)
      state_reg == rmv_pkg::ST_IDLE && tick_reg && run_on
      |=> state_reg == rmv_pkg::ST_FILT && ch_reg == 3'h0;
   endproperty
   a_refresh: assert property (p_refresh) else $error("refresh not started"); // RQ2

   property p_root_len;
      @(posedge clk) disable iff (!rst_n)
      state_reg == rmv_pkg::ST_FILT |=> (state_reg == rmv_pkg::ST_ROOT) [*8];
   endproperty
   a_root_len: assert property (p_root_len) else $error("square root cut short"); // RQ20

   property p_clamp;
      @(posedge clk) disable iff (!rst_n)
      state_reg == rmv_pkg::ST_FILT && corr[49] |=> rad_reg == 48'h0;
   endproperty
   a_clamp: assert property (p_clamp) else $error("negative square not clamped"); // RQ22

   property p_store;
      @(posedge clk) disable iff (!rst_n)
      state_reg == rmv_pkg::ST_STORE |=> rms_reg[$past(ch_reg)] == $past(root_reg);
   endproperty
   a_store: assert property (p_store) else $error("rms result not stored"); // RQ1
endmodule : rmv_measure

/* tb/rmv_host.sv */
// Host model that reaches the measurement registers over Avalon-MM.
// Assumes the bench drives clk and calls the tasks one at a time.
`timescale 1ns/1ps
module rmv_host (
   input wire logic clk,                 // Bus clock.
   output logic [5:0] avs_address,       // Byte address.
   output logic avs_read,                // Read request.
   output logic avs_write,               // Write request.
   output logic [31:0] avs_writedata,    // Write data.
   input wire logic [31:0] avs_readdata, // Read data.
   input wire logic avs_waitrequest      // Slave stall.
);
   // ********************************
   // Bus cycles
   // ********************************
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
   end

   task automatic access(input logic wr, input logic [5:0] addr, input logic [31:0] wdata,
                         output logic [31:0] rdata, output bit ok);
      ok = 1'b0;
      rdata = 32'h0000_0000;
      @(posedge clk);
      avs_address <= addr;
      avs_writedata <= wdata;
      avs_read <= !wr;
      avs_write <= wr;
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) begin
            ok = 1'b1;
            rdata = avs_readdata;
         end
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released lines stop showing the last request.
      avs_address <= ~addr;
      avs_writedata <= ~wdata;
   endtask : access

   function automatic logic [31:0] mav_corrected(input logic [31:0] raw,
                                                 input logic [15:0] gain,
                                                 input logic [31:0] offs);
      return ((raw * gain) >> 8) + offs;
   endfunction : mav_corrected
endmodule : rmv_host

/* tb/tb_top.sv */
// Self-checking bench for the rms and mean-absolute-value block.
// Assumes the host model rmv_host and the package rmv_pkg.
`timescale 1ns/1ps
module tb_top;
   localparam int UPD = 300;
   localparam logic [5:0] OFS = rmv_pkg::OFF_CUR_OFFS;
   localparam logic [5:0] MAV = rmv_pkg::OFF_CUR_MAV;
   localparam logic [5:0] VRM = rmv_pkg::OFF_VOLT_RMS;
   logic clk;
   logic reset_n;
   logic [5:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic signed [23:0] cur_a, cur_b, cur_c, cur_n, volt_a, volt_b, volt_c;
   logic integrator_enable_bit;
   logic computing;
   int fails = 0;
   int total_checks = 0;
   int tick_cnt = 0;
   logic [31:0] v1;
   logic [31:0] v2;

   rmv_measure #(.UPDATE_CYCLES(UPD)) uut (.clk(clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cur_a(cur_a), .cur_b(cur_b), .cur_c(cur_c),
      .cur_n(cur_n), .volt_a(volt_a), .volt_b(volt_b), .volt_c(volt_c),
      .integrator_enable_bit(integrator_enable_bit), .computing(computing));

   rmv_host host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Phase C current is a square wave so the mav path sees an ac signal.
   always @(posedge clk) begin
      if (!reset_n) begin
         tick_cnt <= 0;
         cur_c <= 24'sh0F_0000;
      end else if (tick_cnt == UPD - 1) begin
         tick_cnt <= 0;
         cur_c <= -cur_c;
      end else begin
         tick_cnt <= tick_cnt + 1;
      end
   end

   // ********************************
   // Tasks
   // ********************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [5:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
      bit ok;
      host.access(wr, addr, wdata, rdata, ok);
      if (!ok) begin
         fails++;
         $display("BAD bus answer at %h", addr);
         complete_run();
      end
   endtask : bus

   task automatic rd(input logic [5:0] addr, output logic [31:0] d);
      bus(1'b0, addr, 32'h0000_0000, d);
   endtask : rd

   task automatic rd_chk(input string what, input logic [5:0] addr, input logic [31:0] exp);
      logic [31:0] d;
      rd(addr, d);
      chk(what, exp, d);
   endtask : rd_chk

   task automatic wr(input logic [5:0] addr, input logic [31:0] data);
      logic [31:0] d;
      bus(1'b1, addr, data, d);
   endtask : wr

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask : idle

   // ********************************
   // Sequence
   // ********************************
   initial begin
      reset_n = 1'b0;
      cur_a = 24'sh00_0000;
      cur_b = 24'sh00_0000;
      cur_n = 24'sh00_0000;
      volt_a = 24'sh10_0000;
      volt_b = 24'sh00_0000;
      volt_c = -24'sh10_0000;
      idle(20);
      reset_n <= 1'b1;
      idle(3);
      for (int i = 0; i < 16; i++) begin
         rd_chk("reset word", 6'(i * 4), 32'h0000_0000);
      end
      wr(OFS, 32'hFF00_0200);
      wr(OFS + 6'h04, 32'h007F_FFFF);
      wr(OFS + 6'h08, 32'hFF00_0000);
      wr(OFS + 6'h0C, 32'h0080_0000);
      rd_chk("offset a", OFS, 32'h0000_0200);
      rd_chk("offset b", OFS + 6'h04, 32'h007F_FFFF);
      rd_chk("offset c", OFS + 6'h08, 32'h0000_0000);
      rd_chk("offset n", OFS + 6'h0C, 32'h0F80_0000);
      wr(rmv_pkg::OFF_CUR_RMS, 32'hFFFF_FFFF);
      rd_chk("rms read only", rmv_pkg::OFF_CUR_RMS, 32'h0000_0000);
      wr(rmv_pkg::OFF_CONFIG, 32'hFFFF_FFFF);
      rd_chk("config", rmv_pkg::OFF_CONFIG, 32'h0000_0001);
      idle(3);
      chk("integrator on", 32'h1, {31'h0, integrator_enable_bit});
      wr(rmv_pkg::OFF_CONFIG, 32'h0000_0000);
      idle(3);
      chk("integrator off", 32'h0, {31'h0, integrator_enable_bit});
      idle(UPD * 4);
      rd_chk("idle volt a", VRM, 32'h0000_0000);
      wr(rmv_pkg::OFF_RUN, 32'h0000_0001);
      idle(3);
      chk("computing", 32'h1, {31'h0, computing});
      idle(UPD * 10);
      wr(rmv_pkg::OFF_RUN, 32'h0000_0000);
      idle(UPD * 2);
      rd_chk("cur a rms", rmv_pkg::OFF_CUR_RMS, 32'h0000_0100);
      rd_chk("cur b rms", rmv_pkg::OFF_CUR_RMS + 6'h04, 32'h0000_7FFF);
      rd_chk("cur n rms", rmv_pkg::OFF_CUR_RMS + 6'h0C, 32'h0000_0000);
      rd(rmv_pkg::OFF_CUR_RMS + 6'h08, v1);
      chk("cur c live", 32'h1, {31'h0, v1 != 32'h0});
      rd_chk("volt b rms", VRM + 6'h04, 32'h0000_0000);
      rd(VRM, v1);
      chk("volt a top", 32'h0, {24'h0, v1[31:24]});
      chk("volt a live", 32'h1, {31'h0, v1 != 32'h0});
      rd_chk("volt c rms", VRM + 6'h08, v1);
      rd_chk("mav a", MAV, 32'h0000_0000);
      rd_chk("mav b", MAV + 6'h04, 32'h0000_0000);
      rd(MAV + 6'h08, v2);
      chk("mav c top", 32'h0, {20'h0, v2[31:20]});
      chk("mav c live", 32'h1, {31'h0, v2 != 32'h0});
      chk("mav c fixed", (v2 << 1) + 32'h5, host.mav_corrected(v2, 16'h0200, 32'h5));
      idle(UPD * 2);
      rd_chk("volt a held", VRM, v1);
      wr(rmv_pkg::OFF_RUN, 32'h0000_0001);
      idle(UPD * 10);
      wr(rmv_pkg::OFF_RUN, 32'h0000_0002);
      idle(UPD * 2);
      chk("computing stops", 32'h0, {31'h0, computing});
      rd(VRM, v2);
      chk("volt a grows", 32'h1, {31'h0, v2 > v1});
      rd_chk("cur a again", rmv_pkg::OFF_CUR_RMS, 32'h0000_0100);
      complete_run();
   end
endmodule : tb_top
